// File: logic/sgc_devnum_check.sv
`default_nettype none

// ==========================================================================
// Per downstream port device number filter
module sgc_devnum_check
  import sgc_pkg::*;
(
  input  wire logic       clock,    // Switch clock
  input  wire logic       rstn,     // Async reset, active low
  input  wire logic [1:0] chk_mode, // Check field setting
  input  wire sgc_pkt_t   pkt,      // Packet header summary
  output var  logic       deliver,  // Packet passed, one cycle
  output var  logic       block     // Packet inhibited, one cycle
);

  typedef struct packed {
    logic deliver;
    logic block;
  } sgc_chk_state_t;

  sgc_chk_state_t q;
  sgc_chk_state_t d;

  // ========================================================================
  // Decision per packet, registered so outputs come from flops
  always_comb
  begin
    logic viol;
    viol      = pkt.id_routed && pkt.ds_bus_hit && (pkt.dev_num != 5'h00);
    d         = '0;
    if (pkt.valid)
    begin
      unique case (chk_mode)
        SGC_CHK_ALL:  d.block = viol;
        SGC_CHK_CFG:  d.block = viol && pkt.cfg_req;
        SGC_CHK_NONE: d.block = 1'b0;
        // Reserved code: behave as no checking, software must avoid it
        default:      d.block = 1'b0;
      endcase
      d.deliver = !d.block;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      q <= '0;
    else
      q <= d;
  end

  assign deliver = q.deliver;
  assign block   = q.block;

endmodule

`default_nettype wire

// File: logic/sgc_global_ctrl.sv
`default_nettype none


// ==========================================================================
// Switch global control register and fundamental reset sequencing
module sgc_global_ctrl
  import sgc_pkg::*;
#(
  parameter int NUM_DS = 4                       // Downstream ports filtered
)
(
  input  wire logic            clock,             // Switch clock, 200 MHz
  input  wire logic            rstn,              // Fundamental reset, active low
  input  wire logic            boot_hold_in_reset,// Boot strap pin for hold
  input  wire logic            loader_done,       // Serial config loader finished
  input  wire logic            sw_reset,          // Software reset pulse
  input  wire sgc_req_t        reg_req,           // Register request
  output var  sgc_rsp_t        reg_rsp,           // Register answer
  output var  logic            quasi_reset,       // Held logic kept in reset
  output var  logic            write_lock_release,// Lockable fields open
  output var  logic            budget_value_write_open, // Budget regs open
  output var  logic [1:0]      device_number_check_field, // Check mode
  input  wire sgc_pkt_t [NUM_DS-1:0] pkt_in,      // Per-port packet summary
  output var  logic [NUM_DS-1:0] pkt_deliver,     // Per-port deliver pulse
  output var  logic [NUM_DS-1:0] pkt_block        // Per-port block pulse
);

  // ========================================================================
  // State
  typedef struct packed {
    logic       strap_meta;   // First synchroniser stage
    logic       strap_sync;   // Second synchroniser stage
    logic [1:0] settle;       // Cycles since reset release
    sgc_seq_t   seq;          // Fundamental reset sequence
    sgc_ctrl_t  ctrl;         // Control fields
    logic       quasi;        // Registered quasi-reset level
    sgc_rsp_t   rsp;          // Registered answer
  } sgc_state_t;

  sgc_state_t q;
  sgc_state_t d;

  // ========================================================================
  // Read-back image; reserved bits stay zero
  function automatic logic [31:0] ctrl_word(input sgc_ctrl_t c);
    logic [31:0] w;
    w                          = SGC_CTRL_RESET;
    w[SGC_HOLD_BIT]            = c.hold;
    w[SGC_UNLOCK_BIT]          = c.unlock;
    w[SGC_BUDGET_BIT]          = c.budget_open;
    w[SGC_CHK_HI:SGC_CHK_LO]   = c.chk;
    return w;
  endfunction

  // ========================================================================
  // Next state
  always_comb
  begin
    logic hit;
    logic accept;
    hit    = (reg_req.addr == SGC_CTRL_OFS);
    accept = 1'b0;
    d      = q;

    // Strap crosses two flops before anything reads it
    d.strap_meta = boot_hold_in_reset;
    d.strap_sync = q.strap_meta;

    // Answer is a one-cycle pulse
    d.rsp.ack   = 1'b0;
    d.rsp.rdata = 32'h0000_0000;

    // ----------------------------------------------------------------------
    // Fundamental reset sequence
    unique case (q.seq)
      SGC_SEQ_STRAP:
      begin
        // Wait until the synchroniser holds the real strap level
        if (q.settle == SGC_STRAP_SETTLE)
        begin
          d.ctrl.hold   = q.strap_sync;
          d.ctrl.unlock = 1'b1;
          d.seq         = SGC_SEQ_LOAD;
        end
        else
        begin
          d.settle = q.settle + 2'h1;
        end
      end
      SGC_SEQ_LOAD:
      begin
        // Loader writes lockable fields while unlock is set
        if (loader_done)
          d.seq = SGC_SEQ_HOLD;
      end
      SGC_SEQ_HOLD:
      begin
        // Management master may still preload before release
        if (!q.ctrl.hold)
          d.seq = SGC_SEQ_RUN;
      end
      SGC_SEQ_RUN:
      begin
        d.seq = SGC_SEQ_RUN;
      end
    endcase

    // ----------------------------------------------------------------------
    // Register access
    if (reg_req.req)
    begin
      d.rsp.ack = 1'b1;
      // In quasi-reset only the management port may write; the strap
      // window is closed to all writers so the strap load is not lost
      accept = (q.seq != SGC_SEQ_STRAP) && (!q.quasi || reg_req.smbus);
      if (!reg_req.wr)
      begin
        if (hit)
          d.rsp.rdata = ctrl_word(q.ctrl);
      end
      else if (accept && hit)
      begin
        if (reg_req.be[0])
        begin
          // Hold bit is frozen once the switch has left reset
          if (q.seq != SGC_SEQ_RUN)
            d.ctrl.hold = reg_req.wdata[SGC_HOLD_BIT];
          d.ctrl.unlock = reg_req.wdata[SGC_UNLOCK_BIT];
          // Budget open bit is itself lockable
          if (q.ctrl.unlock)
            d.ctrl.budget_open = reg_req.wdata[SGC_BUDGET_BIT];
        end
        if (reg_req.be[1])
          d.ctrl.chk = reg_req.wdata[SGC_CHK_HI:SGC_CHK_LO];
      end
    end

    // Software reset drops a pending answer but keeps sticky fields
    if (sw_reset)
      d.rsp = '0;

    // Everything except the management path held until running
    d.quasi = d.ctrl.hold || (d.seq != SGC_SEQ_RUN);
  end

  // ========================================================================
  // State register; fields come out of reset at their documented values
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      q                  <= '0;
      q.seq              <= SGC_SEQ_STRAP;
      q.ctrl.hold        <= SGC_HOLD_RST;
      q.ctrl.unlock      <= SGC_UNLOCK_RST;
      q.ctrl.budget_open <= SGC_BUDGET_RST;
      q.ctrl.chk         <= SGC_CHK_RST;
      q.quasi            <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ========================================================================
  // Outputs
  assign reg_rsp                   = q.rsp;
  assign quasi_reset               = q.quasi;
  assign write_lock_release        = q.ctrl.unlock;
  assign budget_value_write_open   = q.ctrl.budget_open;
  assign device_number_check_field = q.ctrl.chk;

  // ========================================================================
  // Downstream device number filters, one per port
  generate
    for (genvar i = 0; i < NUM_DS; i++)
    begin : g_ds
      sgc_pkt_t pkt_live;

      // Held ports see no packets, so no verdict leaves during quasi-reset
      always_comb
      begin
        pkt_live       = pkt_in[i];
        pkt_live.valid = pkt_in[i].valid && !q.quasi;
      end

      sgc_devnum_check u_chk (
        .clock    (clock),
        .rstn     (rstn),
        .chk_mode (q.ctrl.chk),
        .pkt      (pkt_live),
        .deliver  (pkt_deliver[i]),
        .block    (pkt_block[i])
      );
    end
  endgenerate

endmodule

`default_nettype wire

// File: logic/sgc_pkg.sv
`default_nettype none

// ==========================================================================
// Shared constants and carriers for the switch global control block
package sgc_pkg;

  // ========================================================================
  // Register map
  localparam int              SGC_ADDR_W      = 12;
  localparam logic [11:0]     SGC_CTRL_OFS    = 12'h000;
  localparam logic [31:0]     SGC_CTRL_RESET  = 32'h0000_0000;

  // ========================================================================
  // Field positions inside the control word
  localparam int              SGC_HOLD_BIT    = 2;
  localparam int              SGC_UNLOCK_BIT  = 3;
  localparam int              SGC_BUDGET_BIT  = 4;
  localparam int              SGC_CHK_LO      = 9;
  localparam int              SGC_CHK_HI      = 10;

  // ========================================================================
  // Field reset values (hold bit is replaced by the strap)
  localparam logic            SGC_HOLD_RST    = 1'b0;
  localparam logic            SGC_UNLOCK_RST  = 1'b0;
  localparam logic            SGC_BUDGET_RST  = 1'b0;
  localparam logic [1:0]      SGC_CHK_RST     = 2'h0;

  // ========================================================================
  // Device number check encodings
  localparam logic [1:0]      SGC_CHK_ALL     = 2'h0;
  localparam logic [1:0]      SGC_CHK_CFG     = 2'h1;
  localparam logic [1:0]      SGC_CHK_NONE    = 2'h2;

  // ========================================================================
  // Timing: cycles for the strap to cross its two synchroniser stages
  localparam logic [1:0]      SGC_STRAP_SETTLE = 2'h2;

  // ========================================================================
  // Fundamental reset sequence, Gray coded along its path
  typedef enum logic [1:0] {
    SGC_SEQ_STRAP = 2'b00,
    SGC_SEQ_LOAD  = 2'b01,
    SGC_SEQ_HOLD  = 2'b11,
    SGC_SEQ_RUN   = 2'b10
  } sgc_seq_t;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic        req;
    logic        wr;
    logic        smbus;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } sgc_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } sgc_rsp_t;

  typedef struct packed {
    logic       hold;
    logic       unlock;
    logic       budget_open;
    logic [1:0] chk;
  } sgc_ctrl_t;

  typedef struct packed {
    logic       valid;
    logic       id_routed;
    logic       cfg_req;
    logic       ds_bus_hit;
    logic [4:0] dev_num;
  } sgc_pkt_t;

endpackage

`default_nettype wire

// File: sim/sgc_global_ctrl_checker.sv
`default_nettype none

// ==========================================================================
// Port watcher for the global control block
module sgc_global_ctrl_checker
  import sgc_pkg::*;
#(
  parameter int NUM_DS = 4                                 // Ports filtered
)
(
  input  wire logic              clock,                     // Switch clock
  input  wire logic              rstn,                      // Reset, low
  input  wire logic              sw_reset,                  // Soft reset
  input  wire sgc_req_t          reg_req,                   // Request
  input  wire sgc_rsp_t          reg_rsp,                   // Answer
  input  wire logic              quasi_reset,               // Held state
  input  wire logic              write_lock_release,        // Unlock
  input  wire logic              budget_value_write_open,   // Budget open
  input  wire logic [1:0]        device_number_check_field, // Mode
  input  wire sgc_pkt_t [NUM_DS-1:0] pkt_in,                // Packets
  input  wire logic [NUM_DS-1:0] pkt_deliver,               // Deliver
  input  wire logic [NUM_DS-1:0] pkt_block                  // Block
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // Only port 0 watched; the others share the same logic
  logic live0;
  logic viol0;
  assign live0 = pkt_in[0].valid && !quasi_reset;
  assign viol0 = live0 && pkt_in[0].id_routed && pkt_in[0].ds_bus_hit && (pkt_in[0].dev_num != 5'h00);

  property p_ack;
    reg_req.req && !sw_reset ##1 !sw_reset |-> reg_rsp.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_all;
    viol0 && device_number_check_field == SGC_CHK_ALL |=> pkt_block[0] && !pkt_deliver[0];
  endproperty
  a_all: assert property (p_all) else $error("mode all did not block");
  property p_cfg;
    viol0 && device_number_check_field == SGC_CHK_CFG && !pkt_in[0].cfg_req |=> pkt_deliver[0];
  endproperty
  a_cfg: assert property (p_cfg) else $error("mode cfg blocked a non-config packet");
  property p_none;
    live0 && device_number_check_field == SGC_CHK_NONE |=> pkt_deliver[0] && !pkt_block[0];
  endproperty
  a_none: assert property (p_none) else $error("mode none blocked");
  property p_one;
    live0 |=> pkt_deliver[0] != pkt_block[0];
  endproperty
  a_one: assert property (p_one) else $error("packet verdict not exclusive");
  property p_run;
    !quasi_reset |=> !quasi_reset;
  endproperty
  a_run: assert property (p_run) else $error("hold came back after release");
  property p_rsvd;
    reg_rsp.ack |-> (reg_rsp.rdata & 32'hffff_f9e3) == 32'h0000_0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
  property p_hold;
    reg_rsp.ack && reg_rsp.rdata[2] |-> quasi_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("hold bit set but logic running");
  property p_lock;
    !write_lock_release |=> $stable(budget_value_write_open);
  endproperty
  a_lock: assert property (p_lock) else $error("locked budget bit changed");
  property p_quiet;
    quasi_reset |=> !pkt_deliver[0] && !pkt_block[0];
  endproperty
  a_quiet: assert property (p_quiet) else $error("packet verdict while held");
  property p_swr;
    sw_reset |=> !reg_rsp.ack;
  endproperty
  a_swr: assert property (p_swr) else $error("answer kept through soft reset");

  // Main scenarios reached
  c_block: cover property (pkt_block[0]);
  c_run: cover property ($fell(quasi_reset));
  c_open: cover property (reg_rsp.ack && reg_rsp.rdata[4]);
endmodule

bind sgc_global_ctrl sgc_global_ctrl_checker #(.NUM_DS(NUM_DS)) sgc_global_ctrl_checker_inst (
  .clock(clock), .rstn(rstn), .sw_reset(sw_reset), .reg_req(reg_req), .reg_rsp(reg_rsp),
  .quasi_reset(quasi_reset), .write_lock_release(write_lock_release),
  .budget_value_write_open(budget_value_write_open), .device_number_check_field(device_number_check_field),
  .pkt_in(pkt_in), .pkt_deliver(pkt_deliver), .pkt_block(pkt_block)
);

`default_nettype wire

// File: sim/tb.sv
`default_nettype none

// ==========================================================================
// Self-checking bench for the global control register
module tb
  import sgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic boot_hold_in_reset, loader_done, sw_reset;
  logic quasi_reset, write_lock_release, budget_value_write_open;
  logic [1:0] device_number_check_field;
  logic [3:0] pkt_deliver, pkt_block;
  logic [31:0] rd;
  sgc_req_t reg_req;
  sgc_rsp_t reg_rsp;
  sgc_pkt_t [3:0] pkt_in;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  // Expected block pattern per mode, ports 0..3
  logic [3:0] blk [3] = '{4'h3, 4'h2, 4'h0};

  always #2.5 clock = ~clock;

  sgc_global_ctrl sgc_global_ctrl_inst (
    .clock(clock), .rstn(rstn), .boot_hold_in_reset(boot_hold_in_reset), .loader_done(loader_done),
    .sw_reset(sw_reset), .reg_req(reg_req), .reg_rsp(reg_rsp), .quasi_reset(quasi_reset),
    .write_lock_release(write_lock_release), .budget_value_write_open(budget_value_write_open),
    .device_number_check_field(device_number_check_field), .pkt_in(pkt_in),
    .pkt_deliver(pkt_deliver), .pkt_block(pkt_block)
  );

  // ==========================================================================
  // Report and run control
  task automatic stop_test();
    $display("errors %0d checks %0d", fails, n_checks);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, run needs well under 200 cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One request, entered at a falling edge; answer seen one cycle on, then
  // one idle edge so the next call never reassigns req in the same step
  task automatic access(input logic wr, input logic sm, input logic [11:0] a, input logic [31:0] wd);
    reg_req = '{req: 1'b1, wr: wr, smbus: sm, addr: a, be: 4'h3, wdata: wd};
    @(negedge clock);
    check("ack", 32'h1, {31'h0, reg_rsp.ack});
    rd = reg_rsp.rdata;
    reg_req.req = 1'b0;
    @(negedge clock);
  endtask

  task automatic rdchk(input logic [31:0] exp);
    access(1'b0, 1'b1, SGC_CTRL_OFS, 32'h0);
    check("ctrl_word", exp, rd);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    boot_hold_in_reset = 1'b1;
    loader_done = 1'b0;
    sw_reset = 1'b0;
    reg_req = '0;
    pkt_in = '0;
    repeat (20) @(negedge clock);
    check("qr_reset", 32'h1, {31'h0, quasi_reset});
    check("unlock_rst", 32'h0, {31'h0, write_lock_release});
    check("budget_rst", 32'h0, {31'h0, budget_value_write_open});
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    rdchk(32'h0000_000c);
    // Config path writes are shut out while held
    access(1'b1, 1'b0, SGC_CTRL_OFS, 32'h0000_0204);
    rdchk(32'h0000_000c);
    access(1'b1, 1'b1, SGC_CTRL_OFS, 32'hffff_fbff);
    rdchk(32'h0000_021c);
    check("budget_open", 32'h1, {31'h0, budget_value_write_open});
    check("unlock_open", 32'h1, {31'h0, write_lock_release});
    access(1'b1, 1'b1, 12'h004, 32'hffff_ffff);
    access(1'b0, 1'b1, 12'h004, 32'h0);
    check("unmapped", 32'h0, rd);
    access(1'b1, 1'b1, SGC_CTRL_OFS, 32'h0000_0204);
    rdchk(32'h0000_0204);
    access(1'b1, 1'b1, SGC_CTRL_OFS, 32'h0000_0214);
    rdchk(32'h0000_0204);
    check("unlock_shut", 32'h0, {31'h0, write_lock_release});
    check("budget_kept", 32'h0, {31'h0, budget_value_write_open});
    sw_reset = 1'b1;
    @(negedge clock);
    sw_reset = 1'b0;
    rdchk(32'h0000_0204);
    loader_done = 1'b1;
    repeat (2) @(negedge clock);
    check("qr_held", 32'h1, {31'h0, quasi_reset});
    pkt_in[0] = {1'b1, 1'b1, 1'b0, 1'b1, 5'h03};
    @(negedge clock);
    pkt_in = '0;
    check("held_pkt", 32'h0, {24'h0, pkt_block, pkt_deliver});
    access(1'b1, 1'b1, SGC_CTRL_OFS, 32'h0000_0200);
    @(negedge clock);
    check("qr_run", 32'h0, {31'h0, quasi_reset});
    access(1'b1, 1'b0, SGC_CTRL_OFS, 32'h0000_0204);
    rdchk(32'h0000_0200);
    check("qr_stay", 32'h0, {31'h0, quasi_reset});
    // Same four packets under each legal mode
    for (int m = 0; m < 3; m++)
    begin
      access(1'b1, 1'b0, SGC_CTRL_OFS, {21'h0, m[1:0], 9'h0});
      check("mode", {30'h0, m[1:0]}, {30'h0, device_number_check_field});
      pkt_in[0] = {1'b1, 1'b1, 1'b0, 1'b1, 5'h03};
      pkt_in[1] = {1'b1, 1'b1, 1'b1, 1'b1, 5'h01};
      pkt_in[2] = {1'b1, 1'b1, 1'b1, 1'b1, 5'h00};
      pkt_in[3] = {1'b1, 1'b1, 1'b1, 1'b0, 5'h02};
      @(negedge clock);
      pkt_in = '0;
      check("block", {28'h0, blk[m]}, {28'h0, pkt_block});
      check("deliver", {28'h0, ~blk[m]}, {28'h0, pkt_deliver});
    end
    stop_test();
  end
endmodule

`default_nettype wire
